// [verilog/fpm_power_ctrl.sv]
// Function
// - Chip select low means Active power state, from Standby or Busy only
// - Deselected stays Active until operations finish
// - B9h then deselect and delay enters sleep
// - Enter sleep only when embedded op idle
// - Deep sleep ignores all but ABh
// - ABh then deselect and delay gives Standby
// - Idle clock or other code keeps sleeping
`default_nettype none
module fpm_power_ctrl #(
   parameter logic [15:0] ENTRY_CYCLES = fpm_pkg::SLEEP_ENTRY_CYCLES,
   parameter logic [15:0] WAKE_CYCLES = fpm_pkg::WAKE_CYCLES
) (
   input wire logic clock_i,              // Core clock, 100 MHz
   input wire logic nrst_i,               // Async reset, active low
   input wire logic sck_i,                // Serial clock from host
   input wire logic cs_n_i,               // Chip select pin, active low
   input wire logic mosi_i,               // Serial data pin
   input wire logic embedded_op_active_i, // Embedded operation busy flag
   output logic [5:0] power_state_o,      // One-hot power state
   output logic active_o,                 // Active power state
   output logic standby_o,                // Standby power state
   output logic deep_sleep_state_o,       // Deep power down reached
   output logic cmd_valid_o,              // Pulse: command byte forwarded
   output logic [7:0] cmd_byte_o          // Forwarded command byte
);
   fpm_link_if lnk ();

   fpm_cmd_shifter u_shifter (
      .sck_i(sck_i),
      .nrst_i(nrst_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .lnk(lnk)
   );

   // Synchronisers for chip select and the byte toggle
   logic cs_s1, cs_s2, cs_s3;
   logic tg_s1, tg_s2, tg_s3;

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         tg_s1 <= 1'b0;
         tg_s2 <= 1'b0;
         tg_s3 <= 1'b0;
      end
      else
      begin
         cs_s1 <= cs_n_i;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         tg_s1 <= lnk.cmd_toggle;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
      end
   end

   fpm_pkg::fpm_state_type state, next_state;
   logic [15:0] cnt, next_cnt;
   logic sel, next_sel;
   logic got, next_got;
   logic [7:0] cmd_lat, next_cmd_lat;
   logic fwd, next_fwd;
   logic [7:0] fwd_byte, next_fwd_byte;
   logic byte_ev, select_ev, deselect_ev, got_now, sleepy;
   logic [7:0] cmd_now;

   always_comb
   begin
      byte_ev = tg_s2 ^ tg_s3;
      next_sel = (cs_s2 == cs_s3) ? ~cs_s2 : sel;
      select_ev = ~sel & next_sel;
      deselect_ev = sel & ~next_sel;
      // First byte of a frame is its command
      cmd_now = (byte_ev && !got) ? lnk.cmd_byte : cmd_lat;
      got_now = got | byte_ev;
      next_got = select_ev ? 1'b0 : got_now;
      next_cmd_lat = select_ev ? fpm_pkg::CMD_NONE : cmd_now;
      sleepy = (state == fpm_pkg::ST_DEEP) || (state == fpm_pkg::ST_ENTER) ||
               (state == fpm_pkg::ST_WAKE);
      next_fwd = byte_ev & ~sleepy;
      next_fwd_byte = next_fwd ? lnk.cmd_byte : fwd_byte;
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         fpm_pkg::ST_STANDBY:
         begin
            if (select_ev)
               next_state = fpm_pkg::ST_ACTIVE;
         end
         fpm_pkg::ST_ACTIVE:
         begin
            if (deselect_ev)
            begin
               if (got_now && cmd_now == fpm_pkg::CMD_ENTER_SLEEP &&
                   !embedded_op_active_i)
               begin
                  next_state = fpm_pkg::ST_ENTER;
                  next_cnt = 16'(ENTRY_CYCLES - fpm_pkg::CNT_ONE);
               end
               else if (embedded_op_active_i)
                  next_state = fpm_pkg::ST_BUSY;
               else
                  next_state = fpm_pkg::ST_STANDBY;
            end
         end
         fpm_pkg::ST_BUSY:
         begin
            if (select_ev)
               next_state = fpm_pkg::ST_ACTIVE;
            else if (!embedded_op_active_i)
               next_state = fpm_pkg::ST_STANDBY;
         end
         fpm_pkg::ST_ENTER:
         begin
            if (cnt == fpm_pkg::CNT_ZERO)
               next_state = fpm_pkg::ST_DEEP;
            else
               next_cnt = 16'(cnt - fpm_pkg::CNT_ONE);
         end
         fpm_pkg::ST_DEEP:
         begin
            // Only a released frame carrying the wake code leaves sleep
            if (deselect_ev && got_now && cmd_now == fpm_pkg::CMD_WAKE)
            begin
               next_state = fpm_pkg::ST_WAKE;
               next_cnt = 16'(WAKE_CYCLES - fpm_pkg::CNT_ONE);
            end
         end
         fpm_pkg::ST_WAKE:
         begin
            // Select activity here is a host fault and is not acted on
            if (cnt == fpm_pkg::CNT_ZERO)
               next_state = fpm_pkg::ST_STANDBY;
            else
               next_cnt = 16'(cnt - fpm_pkg::CNT_ONE);
         end
         default:
         begin
            next_state = fpm_pkg::ST_STANDBY;
            next_cnt = fpm_pkg::CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state <= fpm_pkg::ST_STANDBY;
         cnt <= fpm_pkg::CNT_ZERO;
         sel <= 1'b0;
         got <= 1'b0;
         cmd_lat <= fpm_pkg::CMD_NONE;
         fwd <= 1'b0;
         fwd_byte <= fpm_pkg::CMD_NONE;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         sel <= next_sel;
         got <= next_got;
         cmd_lat <= next_cmd_lat;
         fwd <= next_fwd;
         fwd_byte <= next_fwd_byte;
      end
   end

   assign power_state_o = state;
   assign active_o = (state == fpm_pkg::ST_ACTIVE) || (state == fpm_pkg::ST_BUSY);
   assign standby_o = (state == fpm_pkg::ST_STANDBY);
   assign deep_sleep_state_o = (state == fpm_pkg::ST_DEEP);
   assign cmd_valid_o = fwd;
   assign cmd_byte_o = fwd_byte;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   property p_select_active;
      $rose(sel) && $past(state == fpm_pkg::ST_STANDBY) |-> state == fpm_pkg::ST_ACTIVE;
   endproperty
   a_select_active: assert property (p_select_active)
      else $error("Select from standby did not give active");

   property p_busy_hold;
      state == fpm_pkg::ST_ACTIVE && deselect_ev && embedded_op_active_i
         |=> state == fpm_pkg::ST_BUSY ##1 (state == fpm_pkg::ST_BUSY || sel ||
         $past(!embedded_op_active_i));
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("Deselect while busy did not hold active");

   property p_busy_release;
      state == fpm_pkg::ST_BUSY && !embedded_op_active_i && !select_ev
         |=> state == fpm_pkg::ST_STANDBY;
   endproperty
   a_busy_release: assert property (p_busy_release)
      else $error("Busy did not return to standby");

   property p_deep_from_enter;
      $rose(state == fpm_pkg::ST_DEEP) |-> $past(state == fpm_pkg::ST_ENTER) &&
         $past(cnt) == fpm_pkg::CNT_ZERO;
   endproperty
   a_deep_from_enter: assert property (p_deep_from_enter)
      else $error("Deep sleep reached without entry delay");

   property p_enter_idle_only;
      state == fpm_pkg::ST_ACTIVE && deselect_ev && embedded_op_active_i
         |=> state != fpm_pkg::ST_ENTER;
   endproperty
   a_enter_idle_only: assert property (p_enter_idle_only)
      else $error("Sleep entry taken while embedded op active");

   property p_deep_ignores;
      state == fpm_pkg::ST_DEEP && byte_ev |=> !cmd_valid_o;
   endproperty
   a_deep_ignores: assert property (p_deep_ignores)
      else $error("Command forwarded during deep sleep");

   property p_wake_done;
      state == fpm_pkg::ST_WAKE && cnt == fpm_pkg::CNT_ZERO |=> standby_o && !deep_sleep_state_o;
   endproperty
   a_wake_done: assert property (p_wake_done)
      else $error("Wake delay end did not give standby");

   property p_stay_asleep;
      state == fpm_pkg::ST_DEEP && !(deselect_ev && got_now && cmd_now == fpm_pkg::CMD_WAKE)
         |=> state == fpm_pkg::ST_DEEP;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep)
      else $error("Deep sleep left without wake code");

   property p_delay_load;
      $rose(state == fpm_pkg::ST_ENTER) |-> cnt == 16'(ENTRY_CYCLES - fpm_pkg::CNT_ONE);
   endproperty
   a_delay_load: assert property (p_delay_load)
      else $error("Entry delay count loaded wrongly");

   property p_wake_load;
      $rose(state == fpm_pkg::ST_WAKE) |-> cnt == 16'(WAKE_CYCLES - fpm_pkg::CNT_ONE);
   endproperty
   a_wake_load: assert property (p_wake_load)
      else $error("Wake delay count loaded wrongly");

   c_deep: cover property (state == fpm_pkg::ST_DEEP);
   c_wake: cover property ($rose(state == fpm_pkg::ST_WAKE));
   c_busy: cover property (state == fpm_pkg::ST_BUSY);
   c_fwd: cover property (cmd_valid_o);
endmodule
`default_nettype wire

// [common/fpm_pkg.sv]
`default_nettype none
package fpm_pkg;
   // Core clock and delay times
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int unsigned WAKE_DELAY_NS = 30000;
   localparam int unsigned CNT_W = 16;
   // Least times round up to whole core cycles
   localparam logic [CNT_W-1:0] SLEEP_ENTRY_CYCLES =
      CNT_W'((SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_CYCLES =
      CNT_W'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // Command codes and framing
   localparam int unsigned CMD_W = 8;
   localparam logic [CMD_W-1:0] CMD_ENTER_SLEEP = 8'hB9;
   localparam logic [CMD_W-1:0] CMD_WAKE = 8'hAB;
   localparam logic [CMD_W-1:0] CMD_NONE = 8'h00;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_STEP = 3'h1;
   typedef enum logic [5:0] {
      ST_STANDBY = 6'h01,
      ST_ACTIVE = 6'h02,
      ST_BUSY = 6'h04,
      ST_ENTER = 6'h08,
      ST_DEEP = 6'h10,
      ST_WAKE = 6'h20
   } fpm_state_type;
endpackage
`default_nettype wire

// [common/fpm_link_if.sv]
`default_nettype none
interface fpm_link_if;
   logic [7:0] cmd_byte;
   logic cmd_toggle;
   modport link (output cmd_byte, output cmd_toggle);
   modport core (input cmd_byte, input cmd_toggle);
endinterface
`default_nettype wire

// [verilog/fpm_cmd_shifter.sv]
`default_nettype none
module fpm_cmd_shifter (
   input wire logic sck_i,            // Serial clock, link domain
   input wire logic nrst_i,           // Async reset, active low
   input wire logic cs_n_i,           // Chip select, active low
   input wire logic mosi_i,           // Serial data in
   fpm_link_if.link lnk               // Command byte and event toggle
);
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic [7:0] cmd;
   logic tog;
   logic [7:0] next_shift;
   logic [2:0] next_bit_cnt;
   logic [7:0] next_cmd;
   logic next_tog;
   logic frame_rst_n;

   // Deselect clears the framing, since the link clock stops between frames
   assign frame_rst_n = nrst_i & ~cs_n_i;

   always_comb
   begin
      next_shift = {shift[6:0], mosi_i};
      next_bit_cnt = 3'(bit_cnt + fpm_pkg::BIT_STEP);
      next_cmd = cmd;
      next_tog = tog;
      if (bit_cnt == fpm_pkg::BIT_LAST)
      begin
         next_cmd = next_shift;
         next_tog = ~tog;
      end
   end

   always_ff @(posedge sck_i or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         shift <= fpm_pkg::CMD_NONE;
         bit_cnt <= fpm_pkg::BIT_FIRST;
      end
      else
      begin
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
      end
   end

   // Byte and toggle survive deselect so the core can still collect them
   always_ff @(posedge sck_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmd <= fpm_pkg::CMD_NONE;
         tog <= 1'b0;
      end
      else
      begin
         cmd <= next_cmd;
         tog <= next_tog;
      end
   end

   assign lnk.cmd_byte = cmd;
   assign lnk.cmd_toggle = tog;
endmodule
`default_nettype wire

// [test/fpm_host_model.sv]
`default_nettype none
module fpm_host_model (
   input wire logic clock_i, // Core clock, frames launch after its falling edge
   output logic sck_o,       // Serial clock, stands low outside frames
   output logic cs_n_o,      // Chip select, active low
   output logic mosi_o       // Serial data, MSB first
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Sends the top nbits of b in one frame; nbits 0 selects with the clock still
   task automatic frame(input logic [7:0] b, input int nbits);
      @(negedge clock_i);
      cs_n_o = 1'b0;
      #3;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         mosi_o = b[i];
         #40 sck_o = 1'b1;
         #40 sck_o = 1'b0;
      end
      #40;
      @(negedge clock_i);
      cs_n_o = 1'b1;
      // Released line shows no stale bit
      mosi_o = ~mosi_o;
      // Deselect gap before any further select
      repeat (6) @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

// [test/fpm_power_ctrl_tb.sv]
`default_nettype none
module fpm_power_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, nrst_i, sck, cs_n, mosi, embedded_op_active;
   logic [5:0] power_state;
   logic active, standby, deep, cmd_valid;
   logic [7:0] cmd_byte, last_byte;
   int mismatches, tests_run, pulses, entry_n, wake_n;
   fpm_host_model fpm_host_model_i (.clock_i(clock_i), .sck_o(sck), .cs_n_o(cs_n),
      .mosi_o(mosi));
   fpm_power_ctrl #(.ENTRY_CYCLES(16'h0004), .WAKE_CYCLES(16'h0006)) fpm_power_ctrl_i (
      .clock_i(clock_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
      .embedded_op_active_i(embedded_op_active), .power_state_o(power_state),
      .active_o(active), .standby_o(standby), .deep_sleep_state_o(deep),
      .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte));
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // Counts forwarded bytes and the cycles spent in each delay state
   always @(negedge clock_i)
   begin
      if (cmd_valid === 1'b1)
      begin
         pulses++;
         last_byte = cmd_byte;
      end
      if (power_state === 6'h08) entry_n++;
      if (power_state === 6'h20) wake_n++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_state(input logic [5:0] exp);
      int n;
      n = 0;
      while (power_state !== exp && n < 300)
      begin
         @(negedge clock_i);
         n++;
      end
      check({2'h0, power_state}, {2'h0, exp});
      if (n == 300 && power_state !== exp) results();
   endtask
   task automatic s_active;
      int p;
      p = pulses;
      embedded_op_active = 1'b0;
      fork
         fpm_host_model_i.frame(8'h05, 8);
         begin
            repeat (20) @(negedge clock_i);
            check({7'h00, active}, 8'h01);
            check({2'h0, power_state}, 8'h02);
         end
      join
      wait_state(6'h01);
      check(8'(pulses - p), 8'h01);
      check(last_byte, 8'h05);
   endtask
   task automatic s_busy;
      embedded_op_active = 1'b1;
      fpm_host_model_i.frame(8'hB9, 8);
      wait_state(6'h04);
      repeat (20) @(negedge clock_i);
      check({2'h0, power_state}, 8'h04);
      check({7'h00, active}, 8'h01);
      check(entry_n[7:0], 8'h00);
      embedded_op_active = 1'b0;
      wait_state(6'h01);
      check({7'h00, standby}, 8'h01);
   endtask
   task automatic s_enter;
      fpm_host_model_i.frame(8'hB9, 8);
      wait_state(6'h10);
      check(entry_n[7:0], 8'h04);
      check({7'h00, deep}, 8'h01);
   endtask
   task automatic s_ignore;
      int p;
      p = pulses;
      fpm_host_model_i.frame(8'h9F, 8);
      fpm_host_model_i.frame(8'hAB, 0);
      fpm_host_model_i.frame(8'hB9, 8);
      repeat (20) @(negedge clock_i);
      check({2'h0, power_state}, 8'h10);
      check(pulses[7:0], p[7:0]);
      check(wake_n[7:0], 8'h00);
   endtask
   task automatic s_wake;
      fpm_host_model_i.frame(8'hAB, 8);
      // No select until standby is back
      wait_state(6'h01);
      check(wake_n[7:0], 8'h06);
      check({7'h00, standby}, 8'h01);
      check({7'h00, deep}, 8'h00);
   endtask
   initial
   begin
      nrst_i = 1'b0;
      embedded_op_active = 1'b0;
      mismatches = 0;
      tests_run = 0;
      pulses = 0;
      entry_n = 0;
      wake_n = 0;
      repeat (8) @(negedge clock_i);
      check({2'h0, power_state}, 8'h01);
      check(cmd_byte, 8'h00);
      nrst_i = 1'b1;
      s_active();
      s_busy();
      s_enter();
      s_ignore();
      s_wake();
      s_active();
      results();
   end
endmodule
`default_nettype wire
